// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import xfr_pkg::*;
    logic aclk = 0, aresetn = 0, go = 0, tx_in_valid = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    // bready and rready stay high: this master takes every answer at once
    logic s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_word_valid, tx_word_valid, irq;
    logic tx_fabric_clk_present = 0, rx_fabric_clk_present = 0, rx_in_valid;
    logic [3:0]   s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
    logic [31:0]  s_axi_wdata = '0, s_axi_rdata, rx_word, rd;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
    logic [19:0]  tx_in = 20'hABCDE, tx_word;
    xfr_lane_t    lo_d = '0, hi_d = '0, rx_lo, rx_hi;
    xfr_clk_src_t tx_wrclk_src, rx_rdclk_src;
    int fail_count = 0, comparisons = 0, n, k;
    always #10 aclk = ~aclk;
    xfr_chan_model i_chan (.*);
    xfr_rx_map i_dut (.*);
    task automatic print_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // a wait that ran out counts as a mismatch and closes the run
    task automatic tmo(input int i);
        if (i >= 50) begin
            fail_count++;
            print_verdict();
        end
    endtask
    // axi4-lite write: each channel dropped once its ready is seen
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        tmo(n);
        rsp = s_axi_bresp;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        tmo(n);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    // expected 16-bit lane slot, pipe mode swaps in the status pair
    function automatic logic [15:0] slot(input xfr_lane_t l, input logic p);
        return {l.rundisp, p ? l.pipe_st : {l.rm_ins, l.rm_del}, l.pattern, l.disperr,
                l.lock, l.data};
    endfunction
    task automatic rx(input logic p);
        go <= 1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            go <= 0;
            if (rx_word_valid) break;
        end
        tmo(k);
        chk("rx_word", {slot(hi_d, p), slot(lo_d, p)}, rx_word);
    endtask
    // four back-to-back receive words and transmit beats, pulses counted
    task automatic burst(input int erx);
        int c, t;
        c = 0;
        t = 0;
        for (k = 0; k < 10; k++) begin
            @(posedge aclk);
            go <= (k < 4);
            tx_in_valid <= (k < 4);
            c += rx_word_valid;
            t += tx_word_valid;
        end
        chk("rx beats", erx, c);
        chk("tx beats", 4, t);
        chk("tx word", 32'h000ABCDE, 32'(tx_word));
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rd_reg(A_CTRL);
        chk("ctrl", 32'h0, rd);
        wr(4'h2, 32'h3F);
        chk("bresp bad", 32'(RESP_SLVERR), 32'(rsp));
        rd_reg(4'h2);
        chk("rresp bad", 32'(RESP_SLVERR), 32'(rsp));
        chk("rdata bad", 32'h0, rd);
        rd_reg(A_CTRL);
        chk("ctrl kept", 32'h0, rd);
        lo_d <= xfr_lane_t'(18'h2A5AA);
        hi_d <= xfr_lane_t'(18'h15A55);
        rx(0);
        wr(A_CTRL, 32'h1);
        chk("bresp", 32'(RESP_OKAY), 32'(rsp));
        rx(1);
        wr(A_CTRL, 32'h0);
        burst(4);
        wr(A_CTRL, 32'h2);
        burst(2);
        for (int t = 0; t < 2; t++) begin
            for (int r = 0; r < 3; r++) begin
                wr(A_CTRL, 32'(t << 2 | r << 4));
                repeat (2) @(posedge aclk);
                chk("tx src", t ? SRC_OWN_TX : SRC_CH0_TX, 32'(tx_wrclk_src));
                chk("rx src", r == 0 ? SRC_CH0_TX : r == 1 ? SRC_OWN_TX : SRC_OWN_RX, 32'(rx_rdclk_src));
            end
        end
        tx_fabric_clk_present <= 1;
        rx_fabric_clk_present <= 1;
        repeat (2) @(posedge aclk);
        chk("tx fab", SRC_FABRIC, 32'(tx_wrclk_src));
        chk("rx fab", SRC_FABRIC, 32'(rx_rdclk_src));
        wr(A_MASK, 32'h0);
        wr(A_IRQ, 32'h1F);
        rx(0);
        chk("irq masked", 32'h0, 32'(irq));
        rd_reg(A_IRQ);
        chk("irq stat", 32'h18, rd);
        rd_reg(A_STAT);
        chk("stat", 32'h1, rd);
        wr(A_MASK, 32'h8);
        repeat (2) @(posedge aclk);
        chk("irq on", 32'h1, 32'(irq));
        wr(A_IRQ, 32'h8);
        repeat (2) @(posedge aclk);
        chk("irq off", 32'h0, 32'(irq));
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- xfr_chan_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// channel side: hands lane words to the block on request
module xfr_chan_model (
    // clock and stimulus
    input  wire logic             aclk,
    input  wire logic             go,
    input  wire xfr_pkg::xfr_lane_t lo_d,
    input  wire xfr_pkg::xfr_lane_t hi_d,
    // lanes toward the block
    output var  logic             rx_in_valid,
    output var  xfr_pkg::xfr_lane_t rx_lo,
    output var  xfr_pkg::xfr_lane_t rx_hi
);
    import xfr_pkg::*;
    // idle lanes flip every cycle so a stale word is never mistaken for data
    always_ff @(posedge aclk) begin
        rx_in_valid <= go;
        rx_lo       <= go ? lo_d : xfr_lane_t'(~rx_lo);
        rx_hi       <= go ? hi_d : xfr_lane_t'(~rx_hi);
    end
endmodule
`default_nettype wire

// ---- xfr_pkg.sv ----
package xfr_pkg;

    // ------------------------------------------------------------
    // packed receive word layout (per 16-bit lane slot)
    // ------------------------------------------------------------
    localparam int unsigned LANE_W     = 16;  // one lane slot in the packed word
    localparam int unsigned HI_BASE    = 16;  // high lane slot starts here
    localparam int unsigned F_DATA_LSB = 0;   // 10-bit received word
    localparam int unsigned F_DATA_MSB = 9;
    localparam int unsigned F_LOCK     = 10;  // word alignment lock
    localparam int unsigned F_DISPERR  = 11;  // disparity error
    localparam int unsigned F_PATTERN  = 12;  // alignment pattern seen
    localparam int unsigned F_RM_DEL   = 13;  // rate match removed data
    localparam int unsigned F_RM_INS   = 14;  // rate match inserted data
    localparam int unsigned F_RUNDISP  = 15;  // running disparity

    // ------------------------------------------------------------
    // register map, byte addresses on the AXI4-Lite bus
    // ------------------------------------------------------------
    localparam logic [3:0] A_CTRL  = 4'h0;   // mode, divider, clock options
    localparam logic [3:0] A_STAT  = 4'h4;   // live state, read only
    localparam logic [3:0] A_IRQ   = 4'h8;   // sticky events, write one to clear
    localparam logic [3:0] A_MASK  = 4'hC;   // interrupt enables
    localparam int unsigned C_PIPE   = 0;    // ctrl: pipe functional mode
    localparam int unsigned C_HALF   = 1;    // ctrl: receive divide by two
    localparam int unsigned C_TXOPT  = 2;    // ctrl: 0 shared, 1 own tx clock
    localparam int unsigned C_RXOPT  = 4;    // ctrl: rx clock option, 2 bits
    localparam int unsigned CTRL_W   = 6;
    localparam int unsigned IRQ_W    = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // interrupt event bits
    localparam int unsigned E_LOCKLOST_LO = 0;
    localparam int unsigned E_LOCKLOST_HI = 1;
    localparam int unsigned E_DISPERR_LO  = 2;
    localparam int unsigned E_DISPERR_HI  = 3;
    localparam int unsigned E_RATEMATCH   = 4;

    // receive clock options as written to ctrl
    localparam logic [1:0] RXOPT_SHARED = 2'h0;
    localparam logic [1:0] RXOPT_OWN_TX = 2'h1;
    localparam logic [1:0] RXOPT_OWN_RX = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_FABRIC,     // core clock supplied by the fabric
        SRC_CH0_TX,     // channel 0 transmit output clock, shared
        SRC_OWN_TX,     // this channel's transmit output clock
        SRC_OWN_RX      // this channel's receive output clock
    } xfr_clk_src_t;

    typedef struct packed {
        logic [9:0] data;      // decoded 10-bit word
        logic       lock;      // alignment lock
        logic       disperr;   // disparity error
        logic       pattern;   // alignment pattern detected
        logic       rm_del;    // rate match removed data
        logic       rm_ins;    // rate match inserted data
        logic [1:0] pipe_st;   // pipe receive status
        logic       rundisp;   // running disparity
    } xfr_lane_t;

endpackage

// ---- xfr_rx_map.sv ----
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module xfr_rx_map (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite register slave
    input  wire logic [3:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output var  logic                 s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output var  logic                 s_axi_wready,
    output var  logic [1:0]           s_axi_bresp,
    output var  logic                 s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [3:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output var  logic                 s_axi_arready,
    output var  logic [31:0]          s_axi_rdata,
    output var  logic [1:0]           s_axi_rresp,
    output var  logic                 s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // receive path from the channel
    input  wire xfr_pkg::xfr_lane_t   rx_lo,
    input  wire xfr_pkg::xfr_lane_t   rx_hi,
    input  wire logic                 rx_in_valid,
    // packed receive word to the fabric
    output var  logic [31:0]          rx_word,
    output var  logic                 rx_word_valid,
    // transmit path from the fabric
    input  wire logic [19:0]          tx_in,
    input  wire logic                 tx_in_valid,
    output var  logic [19:0]          tx_word,
    output var  logic                 tx_word_valid,
    // core clock routing
    input  wire logic                 tx_fabric_clk_present,
    input  wire logic                 rx_fabric_clk_present,
    output var  xfr_pkg::xfr_clk_src_t tx_wrclk_src,
    output var  xfr_pkg::xfr_clk_src_t rx_rdclk_src,
    // interrupt
    output var  logic                 irq
);
    import xfr_pkg::*;

    // ------------------------------------------------------------
    // lane packing
    // ------------------------------------------------------------
    // one function for both lanes keeps every status bit in the same
    // cycle as its word; there is no separate status pipeline to skew
    function automatic logic [LANE_W-1:0] pack_lane(input xfr_lane_t l, input logic pipe);
        logic [LANE_W-1:0] w;
        w = '0;
        w[F_DATA_MSB:F_DATA_LSB] = l.data;
        w[F_LOCK]    = l.lock;
        w[F_DISPERR] = l.disperr;
        w[F_PATTERN] = l.pattern;
        if (pipe) begin
            w[F_RM_INS:F_RM_DEL] = l.pipe_st;
        end else begin
            w[F_RM_DEL] = l.rm_del;
            w[F_RM_INS] = l.rm_ins;
        end
        w[F_RUNDISP] = l.rundisp;
        return w;
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;          // control register
    logic [IRQ_W-1:0]  irq_stat;      // sticky events
    logic [IRQ_W-1:0]  irq_mask;      // enables
    logic              aw_held;       // write address captured
    logic              w_held;        // write data captured
    logic [3:0]        aw_addr;       // held write address
    logic [31:0]       w_data;        // held write data
    logic [3:0]        w_strb;        // held byte enables
    logic [CTRL_W-1:0] next_ctrl;
    logic [IRQ_W-1:0]  next_irq_stat;
    logic [IRQ_W-1:0]  next_irq_mask;
    logic              next_aw_held;
    logic              next_w_held;
    logic [3:0]        next_aw_addr;
    logic [31:0]       next_w_data;
    logic [3:0]        next_w_strb;
    logic              next_awready;
    logic              next_wready;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready;
    logic              next_rvalid;
    logic [1:0]        next_rresp;
    logic [31:0]       next_rdata;
    logic              next_irq;
    logic [IRQ_W-1:0]  events;        // one-cycle event pulses from the datapath

    // ------------------------------------------------------------
    // datapath state
    // ------------------------------------------------------------
    logic              half_phase;    // divide-by-two phase
    logic              capture;       // receive word taken this cycle
    logic              lock_lo_q;     // last seen lock, low lane
    logic              lock_hi_q;     // last seen lock, high lane
    logic              next_half_phase;
    logic              next_lock_lo_q;
    logic              next_lock_hi_q;
    logic [31:0]       next_rx_word;
    logic              next_rx_word_valid;
    logic [19:0]       next_tx_word;
    logic              next_tx_word_valid;
    xfr_clk_src_t      next_tx_src;
    xfr_clk_src_t      next_rx_src;

    // ------------------------------------------------------------
    // bus slave and registers: next values
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wmask;
        wmask         = '0;
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_aw_addr  = aw_addr;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        next_bvalid   = s_axi_bvalid;
        next_bresp    = s_axi_bresp;
        next_rvalid   = s_axi_rvalid;
        next_rresp    = s_axi_rresp;
        next_rdata    = s_axi_rdata;
        next_ctrl     = ctrl;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        // address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // the write commits only once both halves sit in the holding flops
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            for (int b = 0; b < 4; b++) begin
                wmask[b*8 +: 8] = {8{w_strb[b]}};
            end
            unique case (aw_addr)
                A_CTRL: next_ctrl = (ctrl & ~wmask[CTRL_W-1:0])
                                  | (w_data[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
                A_MASK: next_irq_mask = (irq_mask & ~wmask[IRQ_W-1:0])
                                      | (w_data[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
                A_IRQ:  next_irq_stat = irq_stat & ~(w_data[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
                A_STAT: next_bresp = RESP_OKAY;   // read only, write ignored
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // new events always win over a clear in the same cycle
        next_irq_stat = next_irq_stat | events;
        // read channel: one read at a time
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                A_CTRL: next_rdata = {{(32-CTRL_W){1'b0}}, ctrl};
                A_STAT: next_rdata = {24'h000000, rx_rdclk_src, tx_wrclk_src,
                                      half_phase, ctrl[C_HALF], lock_hi_q, lock_lo_q};
                A_IRQ:  next_rdata = {{(32-IRQ_W){1'b0}}, irq_stat};
                A_MASK: next_rdata = {{(32-IRQ_W){1'b0}}, irq_mask};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        next_awready = !next_aw_held;
        next_wready  = !next_w_held;
        next_arready = !next_rvalid;
        next_irq     = |(next_irq_stat & next_irq_mask);
    end

    // bus slave and registers: flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl          <= CTRL_RST;
            irq_stat      <= '0;
            irq_mask      <= '0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= '0;
            irq           <= 1'b0;
        end else begin
            ctrl          <= next_ctrl;
            irq_stat      <= next_irq_stat;
            irq_mask      <= next_irq_mask;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
            irq           <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // receive mapping, divider, transmit pass and clock routing
    // ------------------------------------------------------------
    // the divider only thins the receive stream: the recovered rate is
    // halved locally, so no second transmit pll is needed
    always_comb begin
        next_half_phase = ctrl[C_HALF] ? ~half_phase : 1'b0;
        capture         = rx_in_valid && !(ctrl[C_HALF] && half_phase);
        next_rx_word       = rx_word;
        next_rx_word_valid = capture;
        next_lock_lo_q     = lock_lo_q;
        next_lock_hi_q     = lock_hi_q;
        events             = '0;
        if (capture) begin
            // both lanes and their status leave in one word; pipe mode sends pipe_st in place of rm_del and rm_ins
            next_rx_word = {pack_lane(rx_hi, ctrl[C_PIPE]), pack_lane(rx_lo, ctrl[C_PIPE])};
            next_lock_lo_q = rx_lo.lock;
            next_lock_hi_q = rx_hi.lock;
            events[E_LOCKLOST_LO] = lock_lo_q && !rx_lo.lock;
            events[E_LOCKLOST_HI] = lock_hi_q && !rx_hi.lock;
            events[E_DISPERR_LO]  = rx_lo.disperr;
            events[E_DISPERR_HI]  = rx_hi.disperr;
            events[E_RATEMATCH]   = !ctrl[C_PIPE] && (rx_lo.rm_del || rx_lo.rm_ins
                                                   || rx_hi.rm_del || rx_hi.rm_ins);
        end
        // transmit words pass every cycle, blind to the divider
        next_tx_word       = tx_in_valid ? tx_in : tx_word;
        next_tx_word_valid = tx_in_valid;
        // a fabric clock overrides the option; it must match the output
        // clock frequency, which this logic cannot
        if (tx_fabric_clk_present) begin
            next_tx_src = SRC_FABRIC;
        end else if (ctrl[C_TXOPT]) begin
            next_tx_src = SRC_OWN_TX;
        end else begin
            next_tx_src = SRC_CH0_TX;
        end
        // shared choice assumes every channel keeps the same mode
        if (rx_fabric_clk_present) begin
            next_rx_src = SRC_FABRIC;
        end else begin
            unique case (ctrl[C_RXOPT +: 2])
                RXOPT_SHARED: next_rx_src = SRC_CH0_TX;
                RXOPT_OWN_TX: next_rx_src = SRC_OWN_TX;
                default:      next_rx_src = SRC_OWN_RX;
            endcase
        end
    end

    // datapath flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_phase    <= 1'b0;
            lock_lo_q     <= 1'b0;
            lock_hi_q     <= 1'b0;
            rx_word       <= '0;
            rx_word_valid <= 1'b0;
            tx_word       <= '0;
            tx_word_valid <= 1'b0;
            tx_wrclk_src  <= SRC_CH0_TX;
            rx_rdclk_src  <= SRC_CH0_TX;
        end else begin
            half_phase    <= next_half_phase;
            lock_lo_q     <= next_lock_lo_q;
            lock_hi_q     <= next_lock_hi_q;
            rx_word       <= next_rx_word;
            rx_word_valid <= next_rx_word_valid;
            tx_word       <= next_tx_word;
            tx_word_valid <= next_tx_word_valid;
            tx_wrclk_src  <= next_tx_src;
            rx_rdclk_src  <= next_rx_src;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_lo_word;
        capture |=> rx_word[F_DATA_MSB:F_DATA_LSB] == $past(rx_lo.data);
    endproperty
    a_lo_word: assert property (p_lo_word) else $error("low word misplaced");
    property p_hi_lock;
        capture |=> rx_word[HI_BASE+F_LOCK] == $past(rx_hi.lock)
                 && rx_word[F_LOCK] == $past(rx_lo.lock)
                 && rx_word[HI_BASE+F_DATA_MSB:HI_BASE] == $past(rx_hi.data);
    endproperty
    a_hi_lock: assert property (p_hi_lock) else $error("high lane lock wrong");
    property p_disperr;
        capture |=> rx_word[F_DISPERR] == $past(rx_lo.disperr)
                 && rx_word[HI_BASE+F_DISPERR] == $past(rx_hi.disperr);
    endproperty
    a_disperr: assert property (p_disperr) else $error("disparity error bit wrong");
    property p_pattern;
        capture |=> rx_word[HI_BASE+F_PATTERN] == $past(rx_hi.pattern)
                 && rx_word[F_PATTERN] == $past(rx_lo.pattern);
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern bit wrong");
    property p_rm_del;
        capture && !ctrl[C_PIPE] |=> rx_word[HI_BASE+F_RM_DEL] == $past(rx_hi.rm_del)
                                  && rx_word[F_RM_DEL] == $past(rx_lo.rm_del);
    endproperty
    a_rm_del: assert property (p_rm_del) else $error("removal bit wrong");
    property p_rm_ins;
        capture && !ctrl[C_PIPE] |=> rx_word[F_RM_INS] == $past(rx_lo.rm_ins)
                                  && rx_word[HI_BASE+F_RM_INS] == $past(rx_hi.rm_ins);
    endproperty
    a_rm_ins: assert property (p_rm_ins) else $error("insertion bit wrong");
    property p_rundisp;
        capture |=> rx_word[F_RUNDISP] == $past(rx_lo.rundisp)
                 && rx_word[HI_BASE+F_RUNDISP] == $past(rx_hi.rundisp);
    endproperty
    a_rundisp: assert property (p_rundisp) else $error("running disparity wrong");
    property p_pipe;
        capture && ctrl[C_PIPE] |=> rx_word[HI_BASE+F_RM_INS:HI_BASE+F_RM_DEL] == $past(rx_hi.pipe_st);
    endproperty
    a_pipe: assert property (p_pipe) else $error("pipe status wrong");
    property p_half;
        ctrl[C_HALF] && $stable(ctrl[C_HALF]) && rx_word_valid |=> !rx_word_valid;
    endproperty
    a_half: assert property (p_half) else $error("divider let two words through");
    property p_tx;
        tx_in_valid |=> tx_word_valid && tx_word == $past(tx_in);
    endproperty
    a_tx: assert property (p_tx) else $error("transmit word held back");
    property p_txsrc;
        !tx_fabric_clk_present && !ctrl[C_TXOPT] |=> tx_wrclk_src == SRC_CH0_TX;
    endproperty
    a_txsrc: assert property (p_txsrc) else $error("shared tx clock not chosen");
    property p_rxsrc;
        rx_fabric_clk_present |=> rx_rdclk_src == SRC_FABRIC;
    endproperty
    a_rxsrc: assert property (p_rxsrc) else $error("fabric rx clock ignored");

    c_half:  cover property (ctrl[C_HALF] && rx_word_valid ##2 rx_word_valid);
    c_pipe:  cover property (capture && ctrl[C_PIPE]);
    c_irq:   cover property ($rose(irq));
    c_rxown: cover property (rx_rdclk_src == SRC_OWN_RX);

endmodule

`default_nettype wire
